//--- common/pdci_defs.svh
`ifndef PDCI_DEFS_SVH
`define PDCI_DEFS_SVH

// Slave addresses, 7 bits, chosen by the address-select pin
`define PDCI_DEV_ADDR_PIN_LO 7'h11
`define PDCI_DEV_ADDR_PIN_HI 7'h10

// Word address map
`define PDCI_REG_CTRL        10'h000
`define PDCI_REG_IRQ_EN      10'h001
`define PDCI_VID_FIRST       10'h002
`define PDCI_VID_LAST        10'h00F
`define PDCI_TT_FIRST        10'h011
`define PDCI_TT_LAST         10'h01D
`define PDCI_MSG_FIRST       10'h01E
`define PDCI_MSG_LAST        10'h31D
`define PDCI_MEM_DEPTH       798

// Field positions
`define PDCI_BIT_QUALITY     7
`define PDCI_BIT_TT          6
`define PDCI_BIT_VID         5
`define PDCI_BIT_ERR_LEVEL   4
`define PDCI_BIT_ACQ_TT      1
`define PDCI_BIT_ACQ_VID     0

// Reset values
`define PDCI_CTRL_RST        8'h00
`define PDCI_IRQ_EN_RST      8'h00
`define PDCI_BYTE_ZERO       8'h00

// Bit counter marks within a byte frame
`define PDCI_CNT_BYTE_DONE   4'h8
`define PDCI_CNT_ACK_DONE    4'h9
`define PDCI_CNT_ZERO        4'h0
`define PDCI_CNT_ONE         4'h1

`endif

//--- common/pdci_pkg.sv
`default_nettype none
package pdci_pkg;

  typedef logic [9:0] pdci_waddr_t;
  typedef logic [7:0] pdci_byte_t;

  // Serial slave protocol states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_ACK_DEV,
    ST_WORDADDR,
    ST_ACK_WORD,
    ST_WRDATA,
    ST_ACK_DATA,
    ST_RDDATA,
    ST_RDACK
  } pdci_state_t;

endpackage : pdci_pkg
`default_nettype wire

//--- rtl/pdci_line_edges.sv
`timescale 1ns/100ps
`default_nettype none
module pdci_line_edges (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Bus lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Decoded line events
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      bus_start,
  output logic      bus_stop
);

  logic scl_q;
  logic sda_q;

  // Previous line levels; idle bus is high
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // Data edges with clock high are start and stop conditions
  assign scl_rise  = scl_i & ~scl_q;
  assign scl_fall  = ~scl_i & scl_q;
  assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
  assign bus_stop  = scl_i & scl_q & ~sda_q & sda_i;

endmodule : pdci_line_edges
`default_nettype wire

//--- rtl/pdci_irq_status.sv
`timescale 1ns/100ps
`default_nettype none
module pdci_irq_status #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Events, clear and mask
  input  wire logic [WIDTH-1:0] evt_set,
  input  wire logic             rd_clear,
  input  wire logic [WIDTH-1:0] evt_mask,
  // Sticky flags and interrupt level
  output logic      [WIDTH-1:0] status_q,
  output logic                  irq
);

  if (WIDTH < 1) begin : g_chk
    $error("pdci_irq_status needs at least one event");
  end

  // Sticky flags; a new event beats a clearing read in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~{WIDTH{rd_clear}}) | evt_set;
    end
  end

  // Level output while any enabled flag stands
  assign irq = |(status_q & evt_mask);

endmodule : pdci_irq_status
`default_nettype wire

//--- rtl/pdci_i2c_front.sv
`timescale 1ns/100ps
`default_nettype none
`include "pdci_defs.svh"
// Behaviour
// RQ1: Word address advances after each byte within the video data range 02..0F.
// RQ2: Word address also advances across teletext packet and status message range.
// RQ3: Advance stops at the last address of the range that started it.
// RQ4: Advance continues only while each byte is acknowledged; master acks reads.
// RQ5: Reset leaves the serial interface an idle slave transceiver.
// RQ6: Reset selects strict error level: only fully valid lines flagged.
// RQ7: Reset clears both reception interrupt enables.
// RQ8: Answer slave address chosen by address-select pin; last bit is read/write.
// RQ9: Teletext bytes at 11..1D, status message at 1E..31D, one range.
// RQ10: Write-only enable register: bit 6 teletext, bit 5 video data.
// RQ11: Control bit 4 selects strict or framing-code/start-codeword flagging.
// RQ12: Outside both ranges the word address holds; one register per access.
module pdci_i2c_front #(
  parameter int MEM_DEPTH = `PDCI_MEM_DEPTH
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // Serial bus pins, data is open drain
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  input  wire logic                addr_sel,
  // Decoder storage write port
  input  wire logic                dec_wr_en,
  input  wire pdci_pkg::pdci_waddr_t dec_wr_addr,
  input  wire pdci_pkg::pdci_byte_t  dec_wr_data,
  // Decoder reception events
  input  wire logic                tt_pkt_full_ok,
  input  wire logic                tt_pkt_hdr_ok,
  input  wire logic                vid_line_full_ok,
  input  wire logic                vid_start_ok,
  input  wire logic                sig_quality,
  // Control outputs
  output logic                     error_level_select,
  output logic [1:0]               acq_select,
  output logic                     teletext_pkt_irq_enable,
  output logic                     video_prog_irq_enable,
  output logic                     irq
);
  import pdci_pkg::*;

  // Highest storage word address
  localparam pdci_waddr_t MEM_TOP = pdci_waddr_t'(MEM_DEPTH - 1);

  // Storage must cover the whole map and still fit the ten-bit word address
  if (MEM_DEPTH < `PDCI_MEM_DEPTH || MEM_DEPTH > 1024) begin : g_chk
    $error("pdci_i2c_front: MEM_DEPTH must cover the map and fit 10 bits");
  end

  // Sequencer, shifter and word address
  pdci_state_t state_q;
  logic [3:0]  bitcnt_q;
  pdci_byte_t  shift_q;
  logic        rw_q;
  logic        mack_q;
  pdci_waddr_t waddr_q;

  // Software registers, line driver and storage
  pdci_byte_t  ctrl_q;
  pdci_byte_t  irq_en_q;
  pdci_byte_t  tx_q;
  logic        drive_low_q;
  pdci_byte_t  mem_q [MEM_DEPTH];

  // Line events and frame marks
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        byte_done;
  logic        ack_done;
  logic        dev_match;
  logic        wr_strobe;
  logic        load_evt;
  logic        rd_clear;

  // Read path and interrupt wiring
  pdci_waddr_t next_waddr;
  pdci_waddr_t load_addr;
  pdci_byte_t  load_byte;
  pdci_byte_t  status_byte;
  logic [1:0]  evt_set;
  logic [1:0]  evt_mask;
  logic [1:0]  status_q;

  // Start, stop and clock edge detection
  pdci_line_edges u_edges (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .bus_start (bus_start),
    .bus_stop  (bus_stop)
  );

  // Next word address; holds at a range end or outside the ranges
  // The gap at 010 is in neither range, so the first range never runs into it
  function automatic pdci_waddr_t advance(input pdci_waddr_t a);
    pdci_waddr_t r;
    r = a;
    if (a >= `PDCI_VID_FIRST && a < `PDCI_VID_LAST) begin // RQ1 RQ3
      r = a + 10'h001;
    end else if (a >= `PDCI_TT_FIRST && a < `PDCI_MSG_LAST) begin // RQ2 RQ3 RQ9
      r = a + 10'h001;
    end
    return r; // RQ12
  endfunction : advance

  // Frame position marks, taken at the falling clock edge
  assign byte_done  = scl_fall && (bitcnt_q == `PDCI_CNT_BYTE_DONE);
  assign ack_done   = scl_fall && (bitcnt_q == `PDCI_CNT_ACK_DONE);
  assign dev_match  = shift_q[7:1] == (addr_sel ? `PDCI_DEV_ADDR_PIN_HI : `PDCI_DEV_ADDR_PIN_LO); // RQ8
  assign wr_strobe  = (state_q == ST_WRDATA) && byte_done;
  assign next_waddr = advance(waddr_q);

  // A read byte is fetched when the device takes the data line
  assign load_evt = ack_done && (((state_q == ST_ACK_DEV) && rw_q) || ((state_q == ST_RDACK) && mack_q));
  // Clearing at the fetch, so an event after it waits for the next read
  assign rd_clear = load_evt && (load_addr == `PDCI_REG_CTRL);

  // Status byte: quality, sticky reception flags, control echo
  always_comb begin
    status_byte = `PDCI_BYTE_ZERO;
    status_byte[`PDCI_BIT_QUALITY]   = sig_quality;
    status_byte[`PDCI_BIT_TT]        = status_q[1];
    status_byte[`PDCI_BIT_VID]       = status_q[0];
    status_byte[`PDCI_BIT_ERR_LEVEL] = ctrl_q[`PDCI_BIT_ERR_LEVEL];
    status_byte[`PDCI_BIT_ACQ_TT]    = ctrl_q[`PDCI_BIT_ACQ_TT];
    status_byte[`PDCI_BIT_ACQ_VID]   = ctrl_q[`PDCI_BIT_ACQ_VID];
  end

  // Read source; the enable register is write-only and reads zero
  always_comb begin
    load_addr = (state_q == ST_RDACK) ? next_waddr : waddr_q; // RQ4
    if (load_addr == `PDCI_REG_CTRL) begin
      load_byte = status_byte;
    end else if (load_addr >= `PDCI_VID_FIRST && load_addr <= MEM_TOP) begin
      load_byte = mem_q[load_addr];
    end else begin
      load_byte = `PDCI_BYTE_ZERO;
    end
  end

  // Protocol sequencer; reset leaves an idle slave
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q  <= ST_IDLE; // RQ5
      bitcnt_q <= `PDCI_CNT_ZERO;
      shift_q  <= `PDCI_BYTE_ZERO;
      rw_q     <= 1'b0;
    end else if (bus_start) begin
      state_q  <= ST_DEVADDR;
      bitcnt_q <= `PDCI_CNT_ZERO;
    end else if (bus_stop) begin
      state_q  <= ST_IDLE;
    end else begin
      // Every bit, acknowledge included, is counted on the clock rise
      if (scl_rise && state_q != ST_IDLE) begin
        shift_q  <= {shift_q[6:0], sda_i};
        bitcnt_q <= bitcnt_q + `PDCI_CNT_ONE;
      end
      case (state_q)
        ST_DEVADDR: begin
          if (byte_done) begin
            if (dev_match) begin // RQ8
              state_q <= ST_ACK_DEV;
              rw_q    <= shift_q[0];
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK_DEV: begin
          if (ack_done) begin
            state_q  <= rw_q ? ST_RDDATA : ST_WORDADDR;
            bitcnt_q <= `PDCI_CNT_ZERO;
          end
        end
        ST_WORDADDR: begin
          if (byte_done) begin
            state_q <= ST_ACK_WORD;
          end
        end
        ST_ACK_WORD, ST_ACK_DATA: begin
          if (ack_done) begin
            state_q  <= ST_WRDATA;
            bitcnt_q <= `PDCI_CNT_ZERO;
          end
        end
        ST_WRDATA: begin
          if (byte_done) begin
            state_q <= ST_ACK_DATA;
          end
        end
        ST_RDDATA: begin
          if (byte_done) begin
            state_q <= ST_RDACK;
          end
        end
        ST_RDACK: begin
          if (ack_done) begin
            // A missing master acknowledge ends the read
            state_q  <= mack_q ? ST_RDDATA : ST_IDLE; // RQ4
            bitcnt_q <= `PDCI_CNT_ZERO;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Master acknowledge on the ninth clock of a read byte
  // The fetch at the following fall depends on it, so it is taken at the rise
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mack_q <= 1'b0;
    end else if (state_q == ST_RDACK && scl_rise) begin
      mack_q <= ~sda_i; // RQ4
    end
  end

  // Word address: set by the first written byte, advanced per acked byte
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      waddr_q <= `PDCI_REG_CTRL;
    end else if (state_q == ST_WORDADDR && byte_done) begin
      waddr_q <= {2'b00, shift_q};
    end else if (ack_done && (state_q == ST_ACK_DATA || (state_q == ST_RDACK && mack_q))) begin
      waddr_q <= next_waddr; // RQ1 RQ2 RQ3 RQ4 RQ12
    end
  end

  // Control and interrupt enable registers
  // Other addresses are acked and dropped, so the master never stalls
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q   <= `PDCI_CTRL_RST; // RQ6
      irq_en_q <= `PDCI_IRQ_EN_RST; // RQ7
    end else if (wr_strobe) begin
      if (waddr_q == `PDCI_REG_CTRL) begin
        ctrl_q <= shift_q; // RQ11
      end
      if (waddr_q == `PDCI_REG_IRQ_EN) begin
        irq_en_q <= shift_q; // RQ10
      end
    end
  end

  assign error_level_select      = ctrl_q[`PDCI_BIT_ERR_LEVEL];
  assign acq_select              = {ctrl_q[`PDCI_BIT_ACQ_TT], ctrl_q[`PDCI_BIT_ACQ_VID]};
  assign teletext_pkt_irq_enable = irq_en_q[`PDCI_BIT_TT];
  assign video_prog_irq_enable   = irq_en_q[`PDCI_BIT_VID];

  // Data line driver; changes only while the clock is low
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      drive_low_q <= 1'b0;
      tx_q        <= `PDCI_BYTE_ZERO;
    end else if (bus_start || bus_stop) begin
      // A cut frame always frees the line, so the bus cannot hang on us
      drive_low_q <= 1'b0;
    end else if (scl_fall) begin
      case (state_q)
        ST_DEVADDR: begin
          drive_low_q <= byte_done && dev_match; // RQ8
        end
        ST_WORDADDR, ST_WRDATA: begin
          // Device acknowledges every written byte
          drive_low_q <= byte_done; // RQ4
        end
        ST_ACK_DEV, ST_RDACK: begin
          if (load_evt) begin
            drive_low_q <= ~load_byte[7];
            tx_q        <= {load_byte[6:0], 1'b0};
          end else if (ack_done) begin
            drive_low_q <= 1'b0;
          end
        end
        ST_ACK_WORD, ST_ACK_DATA: begin
          if (ack_done) begin
            drive_low_q <= 1'b0;
          end
        end
        ST_RDDATA: begin
          if (bitcnt_q < `PDCI_CNT_BYTE_DONE) begin
            drive_low_q <= ~tx_q[7];
            tx_q        <= {tx_q[6:0], 1'b0};
          end else begin
            // Release for the master's acknowledge
            drive_low_q <= 1'b0;
          end
        end
        default: begin
          drive_low_q <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = drive_low_q;

  // Decoder fills its storage; no reset, contents are data only
  // Addresses above the top are dropped rather than wrapped
  always_ff @(posedge clk_sys) begin
    if (dec_wr_en && dec_wr_addr <= MEM_TOP) begin
      mem_q[dec_wr_addr] <= dec_wr_data;
    end
  end

  // Flag source follows the error level: strict or framing/start codes
  assign evt_set[1] = error_level_select ? tt_pkt_hdr_ok : tt_pkt_full_ok; // RQ6 RQ11
  assign evt_set[0] = error_level_select ? vid_start_ok : vid_line_full_ok; // RQ6 RQ11
  assign evt_mask   = {teletext_pkt_irq_enable, video_prog_irq_enable}; // RQ7 RQ10

  // Sticky reception flags, cleared by reading the status byte
  // Kept apart so the set-beats-clear order stays in one place
  pdci_irq_status #(
    .WIDTH (2)
  ) u_irq (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .evt_set  (evt_set),
    .rd_clear (rd_clear),
    .evt_mask (evt_mask),
    .status_q (status_q),
    .irq      (irq)
  );

endmodule : pdci_i2c_front
`default_nettype wire

//--- sim/pdci_i2c_front_props.sv
`timescale 1ns/100ps
`default_nettype none
module pdci_i2c_front_props #(
  parameter int MEM_DEPTH = 798
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bus and events
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic tt_pkt_full_ok,
  input wire logic tt_pkt_hdr_ok,
  input wire logic vid_line_full_ok,
  input wire logic vid_start_ok,
  // Control outputs
  input wire logic error_level_select,
  input wire logic teletext_pkt_irq_enable,
  input wire logic video_prog_irq_enable,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // Reset values, judged across the reset itself
  a_reset_slave: assert property (disable iff (1'b0) sys_rst |=> !sda_oe && !sda_o)
    else $error("data driven after reset");
  a_reset_strict: assert property (disable iff (1'b0) sys_rst |=> !error_level_select)
    else $error("loose level after reset");
  a_reset_irq_off: assert property (disable iff (1'b0)
    sys_rst |=> !teletext_pkt_irq_enable && !video_prog_irq_enable && !irq)
    else $error("interrupt live after reset");
  // Interrupt only through a set enable
  a_irq_masked: assert property (irq |-> teletext_pkt_irq_enable || video_prog_irq_enable)
    else $error("interrupt with enables clear");
  // Drive starts only in the clock low phase and is not dropped while the clock is high
  a_ack_in_low: assert property ($rose(sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("drive began with clock high");
  a_oe_holds_high: assert property ($past(sda_oe) && $past(scl_i) && scl_i |-> sda_oe)
    else $error("drive dropped in clock high");
  // Settings land with the write acknowledge, not elsewhere
  a_cfg_at_ack: assert property (!$past(sys_rst) && ($changed(error_level_select)
    || $changed(teletext_pkt_irq_enable) || $changed(video_prog_irq_enable)) |-> $rose(sda_oe))
    else $error("setting moved outside an ack");
  // Source of a rising interrupt follows the error level
  a_irq_cause: assert property ($rose(irq) |-> $rose(teletext_pkt_irq_enable)
    || $rose(video_prog_irq_enable) || ($past(error_level_select)
    ? ($past(tt_pkt_hdr_ok) || $past(vid_start_ok))
    : ($past(tt_pkt_full_ok) || $past(vid_line_full_ok))))
    else $error("interrupt without selected event");
  a_event_irq: assert property (tt_pkt_full_ok && !error_level_select
    && teletext_pkt_irq_enable |=> irq)
    else $error("valid packet gave no interrupt");
  c_irq: cover property ($rose(irq));
  c_ack: cover property ($rose(sda_oe));
  c_loose: cover property ($rose(error_level_select));
endmodule : pdci_i2c_front_props
bind pdci_i2c_front pdci_i2c_front_props #(.MEM_DEPTH(MEM_DEPTH)) u_props (
  .clk_sys, .sys_rst, .scl_i, .sda_o, .sda_oe, .tt_pkt_full_ok, .tt_pkt_hdr_ok,
  .vid_line_full_ok, .vid_start_ok, .error_level_select, .teletext_pkt_irq_enable,
  .video_prog_irq_enable, .irq
);
`default_nettype wire

//--- sim/pdci_i2c_master.sv
`timescale 1ns/100ps
`default_nettype none
module pdci_i2c_master (
  // Clock
  input  wire logic clk_sys,
  // Bus lines, data resolved with pull-up
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe
);
  // Idle bus: clock high, data released
  initial begin
    scl_o  = 1'b1;
    sda_oe = 1'b0;
  end
  // Half bit of four cycles, twice the minimum phase
  task automatic drv(input logic c, input logic d);
    scl_o  <= c;
    sda_oe <= d;
    repeat (4) @(posedge clk_sys);
  endtask : drv
  // Start or repeated start
  task automatic start();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask : start
  // Stop
  task automatic stop();
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
  endtask : stop
  // Byte out MSB first, then sample the ack
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      drv(1'b0, !b[i]);
      drv(1'b1, !b[i]);
    end
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    ack = !sda_i;
  endtask : wbyte
  // Byte in MSB first; ack asks for more
  task automatic rbyte(input logic ack, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      drv(1'b0, 1'b0);
      drv(1'b1, 1'b0);
      b[i] = sda_i;
    end
    drv(1'b0, ack);
    drv(1'b1, ack);
  endtask : rbyte
endmodule : pdci_i2c_master
`default_nettype wire

//--- sim/tb_pdci_i2c_front.sv
`timescale 1ns/100ps
`default_nettype none
`include "pdci_defs.svh"
module tb_pdci_i2c_front;
  import pdci_pkg::*;
  localparam pdci_byte_t AW = {`PDCI_DEV_ADDR_PIN_LO, 1'b0};
  localparam pdci_byte_t AR = {`PDCI_DEV_ADDR_PIN_LO, 1'b1};
  // Bench side; flags = {0, oe, acq, level, tt en, vid en, irq}
  logic        clk_sys     = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        addr_sel    = 1'b0;
  logic        dec_wr_en   = 1'b0;
  pdci_waddr_t dec_wr_addr = 10'h000;
  pdci_byte_t  dec_wr_data = 8'h00;
  logic [3:0]  ev          = 4'h0;
  logic        sig_quality = 1'b1;
  logic        scl;
  logic        m_oe;
  wire logic   sda;
  wire logic [7:0] flags;
  int          failures    = 0;
  int          n_tests     = 0;
  // Pull-up wire, clock
  assign sda = !(flags[6] || m_oe);
  assign flags[7] = 1'b0;
  always #20 clk_sys = ~clk_sys;
  pdci_i2c_front dut (
    .clk_sys, .sys_rst, .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(flags[6]), .addr_sel,
    .dec_wr_en, .dec_wr_addr, .dec_wr_data, .tt_pkt_full_ok(ev[0]), .tt_pkt_hdr_ok(ev[1]),
    .vid_line_full_ok(ev[2]), .vid_start_ok(ev[3]), .sig_quality,
    .error_level_select(flags[3]), .acq_select(flags[5:4]), .teletext_pkt_irq_enable(flags[2]),
    .video_prog_irq_enable(flags[1]), .irq(flags[0])
  );
  pdci_i2c_master m (.clk_sys, .sda_i(sda), .scl_o(scl), .sda_oe(m_oe));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic snd(input pdci_byte_t b, input logic e);
    logic a;
    m.wbyte(b, a);
    n_tests++;
    if (a !== e) begin
      failures++;
      $display("BAD %0t ack %b on %h", $time, a, b);
    end
  endtask : snd
  task automatic wr(input pdci_byte_t wa, input pdci_byte_t d0, input pdci_byte_t d1, input int n);
    m.start();
    snd(AW, 1'b1);
    snd(wa, 1'b1);
    snd(d0, 1'b1);
    if (n > 1) snd(d1, 1'b1);
    m.stop();
  endtask : wr
  // Three bytes; the last one is not acked
  task automatic rd(input pdci_byte_t wa, input pdci_byte_t e0, input pdci_byte_t e1,
                    input pdci_byte_t e2);
    pdci_byte_t b;
    pdci_byte_t e[3];
    e = '{e0, e1, e2};
    m.start();
    snd(AW, 1'b1);
    snd(wa, 1'b1);
    m.start();
    snd(AR, 1'b1);
    for (int i = 0; i < 3; i++) begin
      m.rbyte(i < 2, b);
      chk(b, e[i], "read byte");
    end
    m.stop();
  endtask : rd
  task automatic mem(input pdci_waddr_t a, input pdci_byte_t d);
    dec_wr_en   <= 1'b1;
    dec_wr_addr <= a;
    dec_wr_data <= d;
    @(posedge clk_sys);
    dec_wr_en   <= 1'b0;
    @(posedge clk_sys);
  endtask : mem
  task automatic pulse(input logic [3:0] v);
    ev <= v;
    @(posedge clk_sys);
    ev <= 4'h0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse
  // Second reset with interrupt live
  task automatic t_reset();
    chk(flags, 8'h00, "reset");
    wr(8'h01, 8'h60, 8'h00, 1);
    wr(8'h00, 8'h10, 8'h00, 1);
    pulse(4'h2);
    chk(flags, 8'h0F, "irq set");
    sys_rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk(flags, 8'h00, "re-reset");
  endtask : t_reset
  task automatic t_addr();
    m.start();
    snd({`PDCI_DEV_ADDR_PIN_HI, 1'b0}, 1'b0);
    m.stop();
    addr_sel <= 1'b1;
    m.start();
    snd({`PDCI_DEV_ADDR_PIN_HI, 1'b0}, 1'b1);
    m.stop();
    addr_sel <= 1'b0;
  endtask : t_addr
  // Two bytes to one register: last one wins
  task automatic t_ctrl();
    wr(8'h00, 8'h13, 8'h01, 2);
    chk(flags, 8'h10, "no advance");
    wr(8'h00, 8'h12, 8'h00, 1);
    chk(flags, 8'h28, "level");
    wr(8'h01, 8'h60, 8'h00, 1);
    chk(flags, 8'h2E, "enables");
    wr(8'h01, 8'h40, 8'h00, 1);
    chk(flags, 8'h2C, "tt only");
  endtask : t_ctrl
  task automatic t_irq();
    pulse(4'h8);
    chk(flags, 8'h2C, "masked");
    pulse(4'h2);
    chk(flags, 8'h2D, "header");
    rd(8'h00, 8'hF2, 8'h92, 8'h92);
    chk(flags, 8'h2C, "cleared");
    wr(8'h00, 8'h02, 8'h00, 1);
    pulse(4'h2);
    chk(flags, 8'h24, "strict");
    pulse(4'h1);
    chk(flags, 8'h25, "full");
    pulse(4'h4);
    chk(flags, 8'h25, "vid masked");
    sig_quality <= 1'b0;
    rd(8'h00, 8'h62, 8'h02, 8'h02);
    sig_quality <= 1'b1;
    chk(flags, 8'h24, "cleared again");
  endtask : t_irq
  task automatic t_incr();
    mem(10'h002, 8'h71);
    mem(10'h00E, 8'h0A);
    mem(10'h00F, 8'h0B);
    mem(10'h010, 8'h5A);
    mem(10'h01D, 8'h1C);
    mem(10'h01E, 8'h2D);
    mem(10'h01F, 8'h3E);
    rd(8'h0E, 8'h0A, 8'h0B, 8'h0B);
    rd(8'h10, 8'h5A, 8'h5A, 8'h5A);
    rd(8'h1D, 8'h1C, 8'h2D, 8'h3E);
  endtask : t_incr
  // Refused byte leaves the address where it was
  task automatic t_nack();
    pdci_byte_t b;
    m.start();
    snd(AW, 1'b1);
    snd(8'h02, 1'b1);
    m.start();
    snd(AR, 1'b1);
    m.rbyte(1'b0, b);
    chk(b, 8'h71, "first");
    m.stop();
    m.start();
    snd(AR, 1'b1);
    m.rbyte(1'b0, b);
    chk(b, 8'h71, "held");
    m.stop();
  endtask : t_nack
  task automatic print_verdict();
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_addr();
    t_ctrl();
    t_irq();
    t_incr();
    t_nack();
    print_verdict();
  end
  // Watchdog, about six times the expected run
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
endmodule : tb_pdci_i2c_front
`default_nettype wire
